// >>> pkg/smpc_pkg.sv
// Constants, types and helpers shared by the serial master block
package smpc_pkg;

  typedef logic [7:0] smpc_byte_t;
  typedef logic [8:0] smpc_div_t;
  typedef logic [4:0] smpc_edge_t;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DIV  = 8'h04;
  localparam logic [7:0] OFF_TX   = 8'h08;
  localparam logic [7:0] OFF_RX   = 8'h0C;
  localparam logic [7:0] OFF_STAT = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;

  // Control field positions
  localparam int CTRL_LOW_BIT_FIRST = 0;
  localparam int CTRL_TX_PHASE      = 1;
  localparam int CTRL_RX_PHASE      = 2;
  localparam int CTRL_BIDIR         = 3;
  localparam int CTRL_BIDIR_DRIVE   = 4;
  localparam int CTRL_W             = 5;

  // Status and mask field positions
  localparam int STAT_DONE    = 0;
  localparam int STAT_COLLIDE = 1;
  localparam int STAT_OVERRUN = 2;
  localparam int STAT_W       = 3;
  localparam int STAT_BUSY    = 8;
  localparam int STAT_RX_FULL = 9;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam smpc_div_t         DIV_RST  = 9'h000;
  localparam logic [STAT_W-1:0] STAT_RST = 3'h0;
  localparam logic [STAT_W-1:0] MASK_RST = 3'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Serial clock timing at the 25 MHz reference
  localparam int REF_CLK_PS        = 40000;
  localparam int SCLK_MIN_PERIOD_PS = 83330;
  localparam int SCLK_MAX_PERIOD_PS = 31948880;
  localparam int MIN_PERIOD_CYC = (SCLK_MIN_PERIOD_PS + REF_CLK_PS - 1) / REF_CLK_PS;
  localparam int MAX_HALF_CYC   = SCLK_MAX_PERIOD_PS / (2 * REF_CLK_PS);
  localparam smpc_div_t DIV1_HIGH_CYC = smpc_div_t'(MIN_PERIOD_CYC / 2);
  localparam smpc_div_t DIV1_LOW_CYC  = smpc_div_t'(MIN_PERIOD_CYC - MIN_PERIOD_CYC / 2);
  localparam smpc_div_t MAX_HALF      = smpc_div_t'(MAX_HALF_CYC);
  localparam smpc_edge_t LAST_EDGE    = 5'h0F;

  // Length of the coming serial clock half in reference cycles
  function automatic smpc_div_t smpc_half_len(input smpc_div_t sel, input logic high);
    if (sel == 9'h000) begin
      return high ? DIV1_HIGH_CYC : DIV1_LOW_CYC;
    end
    if (sel >= MAX_HALF) begin
      return MAX_HALF;
    end
    return sel + 9'h001;
  endfunction : smpc_half_len

  function automatic logic smpc_pick(input smpc_byte_t b, input logic lsb_first);
    return lsb_first ? b[0] : b[7];
  endfunction : smpc_pick

  function automatic smpc_byte_t smpc_shift(input smpc_byte_t b, input logic lsb_first);
    return lsb_first ? {1'b0, b[7:1]} : {b[6:0], 1'b0};
  endfunction : smpc_shift

  function automatic smpc_byte_t smpc_insert(input smpc_byte_t b, input logic bit_in,
                                             input logic lsb_first);
    return lsb_first ? {bit_in, b[7:1]} : {b[6:0], bit_in};
  endfunction : smpc_insert

endpackage : smpc_pkg

// >>> pkg/smpc_link_if.sv
// Signals between the controller, the clock generator and the shifter
`timescale 1ns/10ps
interface smpc_link_if;
  logic                 start;
  smpc_pkg::smpc_byte_t tx_byte;
  logic                 lsb_first;
  logic                 tx_phase;
  logic                 rx_phase;
  smpc_pkg::smpc_div_t  div_sel;
  logic                 din;
  logic                 busy;
  logic                 tick;
  logic                 sclk;
  logic                 dout;
  logic                 done;
  smpc_pkg::smpc_byte_t rx_byte;

  modport ctrl  (output start, tx_byte, lsb_first, tx_phase, rx_phase, div_sel, din,
                 input busy, sclk, dout, done, rx_byte);
  modport clk   (input busy, div_sel, output tick, sclk);
  modport shift (input start, tx_byte, lsb_first, tx_phase, rx_phase, tick, din,
                 output busy, dout, done, rx_byte);
endinterface : smpc_link_if

// >>> design/smpc_clkgen.sv
// Serial clock divider: idles low, toggles only while a byte is moving
`timescale 1ns/10ps
module smpc_clkgen (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  smpc_link_if.clk  lnk
);
  smpc_pkg::smpc_div_t cnt_q;
  smpc_pkg::smpc_div_t half;
  logic                sclk_q;

  assign half     = smpc_pkg::smpc_half_len(lnk.div_sel, sclk_q);
  // Compare with >= so a divider change mid-byte cannot stall the clock
  assign lnk.tick = lnk.busy && (cnt_q >= half - 9'h001);
  assign lnk.sclk = sclk_q;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= 9'h000;
      sclk_q <= 1'b0;
    end else if (!lnk.busy) begin
      cnt_q  <= 9'h000;
      sclk_q <= 1'b0;
    end else if (lnk.tick) begin
      cnt_q  <= 9'h000;
      sclk_q <= ~sclk_q;
    end else begin
      cnt_q  <= cnt_q + 9'h001;
    end
  end
endmodule : smpc_clkgen

// >>> design/smpc_shifter.sv
// Byte shifter with independent transmit and receive clock phases
`timescale 1ns/10ps
module smpc_shifter (
  input  wire logic  ref_clk_i,
  input  wire logic  rst_n_i,
  smpc_link_if.shift lnk
);
  smpc_pkg::smpc_byte_t tx_q;
  smpc_pkg::smpc_byte_t rx_q;
  smpc_pkg::smpc_edge_t edge_q;
  logic                 busy_q;
  logic                 dout_q;
  logic                 done_q;
  logic                 lsb_q;
  logic                 txph_q;
  logic                 rxph_q;
  logic                 odd_edge;
  logic                 change_edge;
  logic                 sample_edge;

  assign odd_edge    = ~edge_q[0];
  assign change_edge = txph_q ? odd_edge : ~odd_edge;
  assign sample_edge = rxph_q ? ~odd_edge : odd_edge;

  assign lnk.busy    = busy_q;
  assign lnk.dout    = dout_q;
  assign lnk.done    = done_q;
  assign lnk.rx_byte = rx_q;

  // Bit order and phases are latched at start so a control write cannot change them mid-byte
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_q   <= 8'h00;
      rx_q   <= 8'h00;
      edge_q <= 5'h00;
      busy_q <= 1'b0;
      dout_q <= 1'b0;
      done_q <= 1'b0;
      lsb_q  <= 1'b0;
      txph_q <= 1'b0;
      rxph_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (lnk.start && !busy_q) begin
        busy_q <= 1'b1;
        edge_q <= 5'h00;
        lsb_q  <= lnk.lsb_first;
        txph_q <= lnk.tx_phase;
        rxph_q <= lnk.rx_phase;
        if (!lnk.tx_phase) begin
          dout_q <= smpc_pkg::smpc_pick(lnk.tx_byte, lnk.lsb_first);
          tx_q   <= smpc_pkg::smpc_shift(lnk.tx_byte, lnk.lsb_first);
        end else begin
          tx_q   <= lnk.tx_byte;
        end
      end else if (busy_q && lnk.tick) begin
        edge_q <= edge_q + 5'h01;
        if (change_edge && edge_q != smpc_pkg::LAST_EDGE) begin
          dout_q <= smpc_pkg::smpc_pick(tx_q, lsb_q);
          tx_q   <= smpc_pkg::smpc_shift(tx_q, lsb_q);
        end
        if (sample_edge) begin
          rx_q <= smpc_pkg::smpc_insert(rx_q, lnk.din, lsb_q);
        end
        if (edge_q == smpc_pkg::LAST_EDGE) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end
endmodule : smpc_shifter

// >>> design/smpc_top.sv
// Serial peripheral master with AXI4-Lite registers and interrupt
//
// Notes on behaviour
// - Bit order select 0 shifts MSB first, 1 shifts LSB first, both directions.
// - Both phases 0: first bit valid at once; both sample odd edges.
// - Tx phase 1, rx phase 0: master data after first edge; master samples odd.
// - Tx phase 0, rx phase 1: master data at once; master samples even edges.
// - Both phases 1: data after first edge; both sample even edges.
// - Serial clock period follows divider select, 83.33 ns to 31948.88 ns; the divider gives 120 ns to 31920 ns at 25 MHz.
// - Divider includes divide-by-1; its high and low halves may differ.
// - Phase rules apply unchanged in single-line bidirectional mode.
// - Each transfer moves exactly eight bits each way.
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module smpc_top (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic             serial_clock_out_o,
  output logic             sdo_o,
  output logic             sdo_oe_o,
  input  wire logic        sdo_i,
  input  wire logic        sdi_i,
  output logic             irq_o
);

  smpc_link_if lnk ();

  // Configuration and status state
  logic [smpc_pkg::CTRL_W-1:0] ctrl_q;
  smpc_pkg::smpc_div_t         div_q;
  logic [smpc_pkg::STAT_W-1:0] status_q;
  logic [smpc_pkg::STAT_W-1:0] status_d;
  logic [smpc_pkg::STAT_W-1:0] mask_q;
  logic [smpc_pkg::STAT_W-1:0] stat_set;
  logic [smpc_pkg::STAT_W-1:0] stat_clr;
  smpc_pkg::smpc_byte_t        tx_hold_q;
  smpc_pkg::smpc_byte_t        rx_hold_q;
  logic                        rx_full_q;
  logic                        start_q;
  logic                        oe_q;
  logic                        irq_q;

  // AXI write channel state
  logic                        awready_q;
  logic                        wready_q;
  logic                        bvalid_q;
  logic [1:0]                  bresp_q;
  logic [7:0]                  waddr_q;
  logic [31:0]                 wdata_q;
  logic [3:0]                  wstrb_q;
  logic                        wr_fire;
  logic [31:0]                 wr_merged;

  // AXI read channel state
  logic                        arready_q;
  logic                        rvalid_q;
  logic [31:0]                 rdata_q;
  logic [1:0]                  rresp_q;
  logic                        rd_fire;
  logic [31:0]                 rd_word;
  logic                        busy_any;
  logic                        tx_write;
  logic                        rx_read;

  function automatic logic is_mapped(input logic [7:0] addr);
    return addr == smpc_pkg::OFF_CTRL || addr == smpc_pkg::OFF_DIV ||
           addr == smpc_pkg::OFF_TX   || addr == smpc_pkg::OFF_RX  ||
           addr == smpc_pkg::OFF_STAT || addr == smpc_pkg::OFF_MASK;
  endfunction : is_mapped

  // Byte lanes not strobed keep their old content
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_lanes

  smpc_clkgen u_clkgen (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .lnk       (lnk.clk)
  );

  smpc_shifter u_shifter (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .lnk       (lnk.shift)
  );

  // Link drive from the control side
  assign lnk.start     = start_q;
  assign lnk.tx_byte   = tx_hold_q;
  assign lnk.lsb_first = ctrl_q[smpc_pkg::CTRL_LOW_BIT_FIRST];
  assign lnk.tx_phase  = ctrl_q[smpc_pkg::CTRL_TX_PHASE];
  assign lnk.rx_phase  = ctrl_q[smpc_pkg::CTRL_RX_PHASE];
  assign lnk.div_sel   = div_q;
  // Single-line mode reads back the shared data pin with the same phase rules
  assign lnk.din       = ctrl_q[smpc_pkg::CTRL_BIDIR] ? sdo_i : sdi_i;

  // Pins; slave selects are left to general-purpose outputs elsewhere
  assign serial_clock_out_o = lnk.sclk;
  assign sdo_o              = lnk.dout;
  assign sdo_oe_o           = oe_q;
  assign irq_o              = irq_q;

  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o  = wready_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rdata_o   = rdata_q;
  assign s_axi_rresp_o   = rresp_q;

  // A write completes once both address and data are held
  assign wr_fire  = !awready_q && !wready_q && !bvalid_q;
  assign rd_fire  = s_axi_arvalid_i && arready_q;
  assign busy_any = lnk.busy || start_q;
  assign tx_write = wr_fire && waddr_q == smpc_pkg::OFF_TX && wstrb_q[0];
  assign rx_read  = rd_fire && s_axi_araddr_i == smpc_pkg::OFF_RX;

  always_comb begin
    wr_merged = 32'h0000_0000;
    unique case (waddr_q)
      smpc_pkg::OFF_CTRL: wr_merged = merge_lanes({27'h0, ctrl_q}, wdata_q, wstrb_q);
      smpc_pkg::OFF_DIV:  wr_merged = merge_lanes({23'h0, div_q}, wdata_q, wstrb_q);
      smpc_pkg::OFF_MASK: wr_merged = merge_lanes({29'h0, mask_q}, wdata_q, wstrb_q);
      default:            wr_merged = merge_lanes(32'h0000_0000, wdata_q, wstrb_q);
    endcase
  end

  // Write address channel
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      awready_q <= 1'b1;
      waddr_q   <= 8'h00;
    end else if (s_axi_awvalid_i && awready_q) begin
      awready_q <= 1'b0;
      waddr_q   <= {s_axi_awaddr_i[7:2], 2'h0};
    end else if (bvalid_q && s_axi_bready_i) begin
      awready_q <= 1'b1;
    end
  end

  // Write data channel
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wready_q <= 1'b1;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid_i && wready_q) begin
      wready_q <= 1'b0;
      wdata_q  <= s_axi_wdata_i;
      wstrb_q  <= s_axi_wstrb_i;
    end else if (bvalid_q && s_axi_bready_i) begin
      wready_q <= 1'b1;
    end
  end

  // Write response
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bvalid_q <= 1'b0;
      bresp_q  <= smpc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= is_mapped(waddr_q) ? smpc_pkg::RESP_OKAY : smpc_pkg::RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= smpc_pkg::CTRL_RST;
      div_q  <= smpc_pkg::DIV_RST;
      mask_q <= smpc_pkg::MASK_RST;
    end else if (wr_fire) begin
      if (waddr_q == smpc_pkg::OFF_CTRL) begin
        ctrl_q <= wr_merged[smpc_pkg::CTRL_W-1:0];
      end
      if (waddr_q == smpc_pkg::OFF_DIV) begin
        div_q <= wr_merged[8:0];
      end
      if (waddr_q == smpc_pkg::OFF_MASK) begin
        mask_q <= wr_merged[smpc_pkg::STAT_W-1:0];
      end
    end
  end

  // Data line drive: always in full duplex, by direction bit in single-line mode
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= !ctrl_q[smpc_pkg::CTRL_BIDIR] || ctrl_q[smpc_pkg::CTRL_BIDIR_DRIVE];
    end
  end

  // Transfer start; a write during a transfer is dropped and flagged
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_q   <= 1'b0;
      tx_hold_q <= 8'h00;
    end else begin
      start_q <= 1'b0;
      if (tx_write && !busy_any) begin
        start_q   <= 1'b1;
        tx_hold_q <= wdata_q[7:0];
      end
    end
  end

  // Received byte is held until the next completed transfer
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_hold_q <= 8'h00;
      rx_full_q <= 1'b0;
    end else begin
      if (lnk.done) begin
        rx_hold_q <= lnk.rx_byte;
        rx_full_q <= 1'b1;
      end else if (rx_read) begin
        rx_full_q <= 1'b0;
      end
    end
  end

  // Sticky events; a new event wins over a same-cycle clear
  always_comb begin
    stat_set = '0;
    stat_set[smpc_pkg::STAT_DONE]    = lnk.done;
    stat_set[smpc_pkg::STAT_COLLIDE] = tx_write && busy_any;
    stat_set[smpc_pkg::STAT_OVERRUN] = lnk.done && rx_full_q && !rx_read;
    stat_clr = '0;
    if (wr_fire && waddr_q == smpc_pkg::OFF_STAT && wstrb_q[0]) begin
      stat_clr = wdata_q[smpc_pkg::STAT_W-1:0];
    end
    status_d = (status_q & ~stat_clr) | stat_set;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_q <= smpc_pkg::STAT_RST;
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

  // Read data selection
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr_i[7:2])
      smpc_pkg::OFF_CTRL[7:2]: rd_word[smpc_pkg::CTRL_W-1:0] = ctrl_q;
      smpc_pkg::OFF_DIV[7:2]:  rd_word[8:0] = div_q;
      smpc_pkg::OFF_TX[7:2]:   rd_word[7:0] = tx_hold_q;
      smpc_pkg::OFF_RX[7:2]:   rd_word[7:0] = rx_hold_q;
      smpc_pkg::OFF_STAT[7:2]: begin
        rd_word[smpc_pkg::STAT_W-1:0]  = status_q;
        rd_word[smpc_pkg::STAT_BUSY]    = busy_any;
        rd_word[smpc_pkg::STAT_RX_FULL] = rx_full_q;
      end
      smpc_pkg::OFF_MASK[7:2]: rd_word[smpc_pkg::STAT_W-1:0] = mask_q;
      default:                 rd_word = 32'h0000_0000;
    endcase
  end

  // Read channel: one read in flight, address taken only while idle
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= smpc_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_word;
      rresp_q   <= is_mapped({s_axi_araddr_i[7:2], 2'h0}) ?
                   smpc_pkg::RESP_OKAY : smpc_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready_i) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

endmodule : smpc_top

// >>> tb/smpc_monitor.sv
// Port checker for the serial master top
`timescale 1ns/10ps
module smpc_monitor (
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  s_axi_awaddr_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        serial_clock_out_o,
  input wire logic        sdo_o,
  input wire logic        sdo_oe_o,
  input wire logic        irq_o
);
  logic [7:0]  aw_q;
  logic [31:0] wd_q;
  logic        bv_q;
  logic        sclk_q;
  logic [4:0]  ctrl_q;
  logic [8:0]  div_q;
  logic [2:0]  mask_q;
  logic [4:0]  edges_q;
  logic [8:0]  run_q;
  logic [8:0]  half_exp;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_q <= 8'h00;
      wd_q <= 32'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) aw_q <= s_axi_awaddr_i;
      if (s_axi_wvalid_i && s_axi_wready_o) wd_q <= s_axi_wdata_i;
    end
  end

  // Settings shadow
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bv_q   <= 1'b0;
      ctrl_q <= 5'h00;
      div_q  <= 9'h000;
      mask_q <= 3'h0;
    end else begin
      bv_q <= s_axi_bvalid_o;
      if (s_axi_bvalid_o && !bv_q) begin
        if (aw_q[7:2] == smpc_pkg::OFF_CTRL[7:2]) ctrl_q <= wd_q[4:0];
        if (aw_q[7:2] == smpc_pkg::OFF_DIV[7:2]) div_q <= wd_q[8:0];
        if (aw_q[7:2] == smpc_pkg::OFF_MASK[7:2]) mask_q <= wd_q[2:0];
      end
    end
  end

  // Edges since byte start; idle 16
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_q  <= 1'b0;
      edges_q <= 5'h10;
      run_q   <= 9'h000;
    end else begin
      sclk_q <= serial_clock_out_o;
      if (s_axi_bvalid_o && !bv_q && aw_q[7:2] == smpc_pkg::OFF_TX[7:2] && edges_q == 5'h10)
        edges_q <= 5'h00;
      else if (serial_clock_out_o != sclk_q) edges_q <= edges_q + 5'h01;
      if (serial_clock_out_o != sclk_q) run_q <= 9'h001;
      else if (run_q != 9'h1FF) run_q <= run_q + 9'h001;
    end
  end

  always_comb begin
    if (div_q == 9'h000) half_exp = serial_clock_out_o ? 9'h002 : 9'h001;
    else if (div_q >= 9'h18E) half_exp = 9'h18F;
    else half_exp = div_q + 9'h001;
  end

  property p_edge_cap;
    edges_q <= 5'h10;
  endproperty
  a_edge_cap: assert property (p_edge_cap) else $error("more than 16 clock edges");

  property p_idle_low;
    edges_q == 5'h10 |-> !serial_clock_out_o;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("clock not low at rest");

  property p_odd_rise;
    $changed(serial_clock_out_o) |-> serial_clock_out_o != edges_q[0];
  endproperty
  a_odd_rise: assert property (p_odd_rise) else $error("odd edge not rising");

  property p_sdo_edges;
    $changed(sdo_o) && sdo_oe_o && edges_q != 5'h00
      |-> $changed(serial_clock_out_o) && edges_q[0] != ctrl_q[1];
  endproperty
  a_sdo_edges: assert property (p_sdo_edges) else $error("data out moved off its edge");

  property p_half_len;
    $changed(serial_clock_out_o) && edges_q != 5'h00 |-> run_q == half_exp;
  endproperty
  a_half_len: assert property (p_half_len) else $error("clock half length wrong");

  property p_done_irq;
    $changed(serial_clock_out_o) && edges_q == 5'h0F && mask_q[0] |-> ##[1:3] irq_o;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("no interrupt after byte");

  property p_mask_off;
    mask_q == 3'h0 |=> !irq_o;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("interrupt while masked");

  property p_bresp;
    $rose(s_axi_bvalid_o) |-> s_axi_bresp_o == (aw_q[7:2] <= 6'h05 ?
      smpc_pkg::RESP_OKAY : smpc_pkg::RESP_SLVERR);
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response code wrong");
endmodule : smpc_monitor

bind smpc_top smpc_monitor u_mon (.*);

// >>> tb/smpc_slave_model.sv
// Behavioural serial slave on the far side of the data lines
`timescale 1ns/10ps
module smpc_slave_model (
  input  wire logic       sclk_i,
  input  wire logic       sel_i,
  input  wire logic       mosi_i,
  input  wire logic       lsb_first_i,
  input  wire logic       tx_phase_i,
  input  wire logic       rx_phase_i,
  input  wire logic [7:0] tx_byte_i,
  output logic            miso_o,
  output logic [7:0]      rx_byte_o
);
  logic [7:0] sh;
  logic [4:0] cnt;
  logic       vis;
  logic       junk = 1'b0;

  // Released line must not hold a stale bit
  always #17 junk = ~junk;

  always @(posedge sel_i) begin
    sh = tx_byte_i;
    cnt = 5'h00;
    rx_byte_o = 8'h00;
    vis = !rx_phase_i;
  end

  always @(sclk_i) begin
    if (sel_i) begin
      cnt = cnt + 5'h01;
      if (cnt[0] != tx_phase_i) begin
        rx_byte_o = lsb_first_i ? {mosi_i, rx_byte_o[7:1]} : {rx_byte_o[6:0], mosi_i};
      end
      if (rx_phase_i && cnt == 5'h01) vis = 1'b1;
      if (cnt[0] == rx_phase_i && cnt > 5'h01 && cnt < 5'h10) begin
        sh = lsb_first_i ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
      end
    end
  end

  assign miso_o = (sel_i && vis) ? (lsb_first_i ? sh[0] : sh[7]) : junk;
endmodule : smpc_slave_model

// >>> tb/smpc_top_bench.sv
// Self-checking bench for the serial master top
`timescale 1ns/10ps
module smpc_top_bench;
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic [7:0]  awaddr    = 8'h00;
  logic        awvalid   = 1'b0;
  logic [31:0] wdata     = 32'h0;
  logic        wvalid    = 1'b0;
  logic        bready    = 1'b1;
  logic [7:0]  araddr    = 8'h00;
  logic        arvalid   = 1'b0;
  logic        rready    = 1'b1;
  logic        sel       = 1'b0;
  logic [4:0]  ctl       = 5'h00;
  logic [7:0]  sl_tx     = 8'h00;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        sclk, sdo, sdo_oe, miso, irq;
  logic [7:0]  sl_rx;
  wire         line = sdo_oe ? sdo : miso;
  int          failures = 0;
  int          num_checks = 0;
  int          cycles = 0;

  always #20 ref_clk_i = ~ref_clk_i;

  smpc_top dut (.ref_clk_i, .rst_n_i, .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .serial_clock_out_o(sclk), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .sdo_i(line),
    .sdi_i(miso), .irq_o(irq));

  smpc_slave_model u_slave (.sclk_i(sclk), .sel_i(sel), .mosi_i(line),
    .lsb_first_i(ctl[0]), .tx_phase_i(ctl[1]), .rx_phase_i(ctl[2]), .tx_byte_i(sl_tx),
    .miso_o(miso), .rx_byte_o(sl_rx));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
  endfunction : lfsr

  function automatic logic [1:0] exp_resp(input logic [7:0] a);
    return (a[7:2] <= 6'h05) ? smpc_pkg::RESP_OKAY : smpc_pkg::RESP_SLVERR;
  endfunction : exp_resp

  // Looped-back line returns the driver's own byte
  function automatic logic [7:0] exp_rx(input logic echo, input logic [7:0] m, s);
    return echo ? m : s;
  endfunction : exp_rx

  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    @(posedge ref_clk_i);
    while (awvalid || wvalid) begin
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      @(posedge ref_clk_i);
    end
    while (!bvalid) @(posedge ref_clk_i);
    check("bresp", bresp, exp_resp(a));
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge ref_clk_i); while (!arready);
    arvalid <= 1'b0;
    do @(posedge ref_clk_i); while (!rvalid);
    d = rdata;
    check("rresp", rresp, exp_resp(a));
  endtask : axi_rd

  task automatic print_verdict();
    if (failures == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      print_verdict();
    end
  end

  initial begin
    logic [31:0] d;
    logic [31:0] seed;
    logic [7:0]  tx_b;
    logic [8:0]  divs [10];
    divs = '{9'h000, 9'h001, 9'h002, 9'h005, 9'h000, 9'h003, 9'h1F4, 9'h001, 9'h000, 9'h002};
    seed = 32'h000146ED;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    for (int k = 0; k < 6; k++) begin
      axi_rd(8'(4 * k), d);
      check("reset value", d, 32'h0);
    end
    axi_rd(8'h40, d);
    check("unmapped read", d, 32'h0);
    axi_wr(8'h3C, 32'hFFFFFFFF);
    for (int i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      tx_b = seed[7:0];
      sl_tx <= seed[15:8];
      ctl <= {1'(i == 9), 1'(i >= 8), 3'(i)};
      sel <= 1'b1;
      @(posedge ref_clk_i);
      axi_wr(smpc_pkg::OFF_CTRL, {27'h0, ctl});
      axi_wr(smpc_pkg::OFF_DIV, {23'h0, divs[i]});
      axi_wr(smpc_pkg::OFF_MASK, (i == 7) ? 32'h0 : 32'h1);
      axi_wr(smpc_pkg::OFF_TX, {24'h0, tx_b});
      if (i == 3) axi_wr(smpc_pkg::OFF_TX, 32'h0);
      d = 32'h0;
      for (int n = 0; n < 5000 && d[0] !== 1'b1; n++) axi_rd(smpc_pkg::OFF_STAT, d);
      check("status", {d[9:8], d[1:0]}, {2'h2, 1'(i == 3), 1'b1});
      check("irq", irq, (i != 7));
      check("oe", sdo_oe, !(ctl[3] && !ctl[4]));
      check("slave byte", sl_rx, exp_rx(ctl[3] && !ctl[4], sl_tx, tx_b));
      axi_rd(smpc_pkg::OFF_RX, d);
      check("rx byte", d[7:0], exp_rx(ctl[3] && ctl[4], tx_b, sl_tx));
      sel <= 1'b0;
      axi_wr(smpc_pkg::OFF_STAT, 32'h7);
      axi_rd(smpc_pkg::OFF_STAT, d);
      check("status clear", {d[9], d[2:0]}, 4'h0);
      check("irq clear", irq, 1'b0);
    end
    print_verdict();
  end
endmodule : smpc_top_bench
